// ===== inc/pcie_link_regs_pkg.sv
// link capability/control register constants: offsets, fields, reset values
// assumes a 32-bit AHB-Lite register port decoding the low 12 address bits
package pcie_link_regs_pkg;
	localparam logic [11:0] LINK_CAP_OFS   = 12'h0cc;
	localparam logic [11:0] LINK_CTRL_OFS  = 12'h0d0;
	localparam logic [11:0] INT_STATUS_OFS = 12'h0e0;
	localparam logic [11:0] INT_ENABLE_OFS = 12'h0e4;
	localparam logic [11:0] INT_CLEAR_OFS  = 12'h0e8;
	localparam int DEC_W = 12;

	// capability field positions
	localparam int CAP_SPEED_LSB = 0;
	localparam int CAP_WIDTH_LSB = 4;
	localparam int CAP_ASPM_LSB  = 10;
	localparam int CAP_L0S_LSB   = 12;
	localparam int CAP_L1_LSB    = 15;
	localparam int CAP_DLL_BIT   = 20;
	localparam int CAP_BWN_BIT   = 21;
	localparam int CAP_PORT_LSB  = 24;

	// capability reset values
	localparam logic [3:0] MAX_SPEED_RST = 4'h2;
	localparam logic [5:0] MAX_WIDTH_RST = 6'h01;
	localparam logic [1:0] ASPM_SUP_RST  = 2'h0;
	localparam logic [2:0] L0S_EXIT_RST  = 3'h3;
	localparam logic [2:0] L1_EXIT_RST   = 3'h0;

	// control field positions
	localparam int CTL_ASPM_LSB = 0;
	localparam int CTL_RCB      = 3;
	localparam int CTL_LINK_DIS = 4;
	localparam int CTL_RETRAIN  = 5;
	localparam int CTL_CCLK     = 6;
	localparam int CTL_EXT_SYNC = 7;
	localparam int CTL_HAWD     = 9;
	localparam int CTL_LBMIE    = 10;
	localparam int CTL_LABIE    = 11;

	// ordered set counts when extended synch is on
	localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;
	localparam logic [10:0] EXT_TS1_COUNT = 11'h400;

	// interrupt bits
	localparam int INT_W       = 2;
	localparam int INT_BW_MGMT = 0;
	localparam int INT_AUTO_BW = 1;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// exit latency figures reported by the encodings
	localparam int CLK_PERIOD_NS = 40;
	localparam int L0S_EXIT_NS   = 256;
	localparam int L0S_EXIT_CYC  = (L0S_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int L1_EXIT_US    = 16;
	localparam int L1_EXIT_CYC   = (L1_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== logic/pcie_port_link_cap_ctrl_regs.sv
// per-port link capability and link control registers behind an AHB-Lite slave
// assumes hready is the bus hready (this slave's hreadyout), all inputs on hclk
//
// Summary of operation
// - max link speed field is read-only, resets to 5 Gb/s, side-loadable
// - max link width field is read-only, resets to one lane
// - ASPM support field is read-only, resets to 00b, side-loadable
// - L0s exit latency field resets to 011b, 256 to below 512 ns
// - L1 exit latency field resets to 000b, side-loadable
// - DLL active reporting bit zero upstream, one on capable downstream ports
// - bandwidth notification bit zero upstream, one downstream
// - port number field resets to the port index, side-loadable
// - ASPM control field selects L0s and L1 entry, resets to 00b
// - receiver may always enter L0s, whatever the ASPM control field
// - read completion boundary bit always reads zero
// - link disable is zero upstream, disables downstream link when set
// - retrain bit starts retraining downstream, always reads zero
// - common clock bit records the clocking scheme, resets to zero
// - extended synch selects 4096 FTS and 1024 TS1 ordered sets
// - hardware autonomous width disable is read-write, resets to zero
// - bandwidth interrupt enables are read-only upstream, writable downstream
`timescale 1ns/1ps
module pcie_port_link_cap_ctrl_regs #(
	parameter int          PORT_INDEX = 0,
	parameter logic [12:0] NORM_FTS   = 13'h0080,
	parameter logic [10:0] NORM_TS1   = 11'h010
) (
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	input  wire  logic        cap_load,
	input  wire  logic [31:0] cap_load_data,
	input  wire  logic        dl_active_rpt_capable,
	input  wire  logic        bw_mgmt_event,
	input  wire  logic        auto_bw_event,
	output logic [1:0]        aspm_ctrl,
	output logic              rx_l0s_allowed,
	output logic              link_disable,
	output logic              retrain_start,
	output logic              common_clock,
	output logic              ext_synch,
	output logic              hw_width_disable,
	output logic              bw_mgmt_int_en,
	output logic              auto_bw_int_en,
	output logic [12:0]       fts_count,
	output logic [10:0]       ts1_count,
	output logic              irq
);
	localparam logic UPSTREAM = (PORT_INDEX == 0);
	localparam logic [7:0] PORT_RST = 8'(PORT_INDEX);

	logic                    take;
	logic                    wr_pend;
	logic                    rd_pend;
	logic [11:0]             wr_addr;
	logic [11:0]             rd_addr;
	logic                    wr_ctrl;
	logic                    wr_inten;
	logic                    wr_clr;
	logic [3:0]              max_speed;
	logic [1:0]              aspm_support;
	logic [2:0]              l0s_exit;
	logic [2:0]              l1_exit;
	logic [7:0]              port_num;
	logic [pcie_link_regs_pkg::INT_W-1:0] int_status;
	logic [pcie_link_regs_pkg::INT_W-1:0] int_enable;
	logic [pcie_link_regs_pkg::INT_W-1:0] int_set;
	logic [pcie_link_regs_pkg::INT_W-1:0] int_clr;
	logic [31:0]             cap_word;
	logic [31:0]             ctrl_word;
	logic [31:0]             rd_word;

	// address phase capture; hsize is not checked, only words are expected
	assign take     = hsel && hready && (htrans == pcie_link_regs_pkg::HTRANS_NONSEQ);
	assign wr_ctrl  = wr_pend && (wr_addr == pcie_link_regs_pkg::LINK_CTRL_OFS);
	assign wr_inten = wr_pend && (wr_addr == pcie_link_regs_pkg::INT_ENABLE_OFS);
	assign wr_clr   = wr_pend && (wr_addr == pcie_link_regs_pkg::INT_CLEAR_OFS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 12'h000;
			rd_addr <= 12'h000;
		end else begin
			wr_pend <= take && hwrite;
			rd_pend <= take && !hwrite;
			if (take) begin
				wr_addr <= haddr[pcie_link_regs_pkg::DEC_W-1:0];
				rd_addr <= haddr[pcie_link_regs_pkg::DEC_W-1:0];
			end
		end
	end

	// reads take one wait state so that a write just before is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= !(take && !hwrite);
			hresp     <= 1'b0;
		end
	end

	// capability word, reserved bits 19:18 and 23:22 read zero
	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[pcie_link_regs_pkg::CAP_SPEED_LSB +: 4] = max_speed;
		cap_word[pcie_link_regs_pkg::CAP_WIDTH_LSB +: 6] = pcie_link_regs_pkg::MAX_WIDTH_RST;
		cap_word[pcie_link_regs_pkg::CAP_ASPM_LSB +: 2] = aspm_support;
		cap_word[pcie_link_regs_pkg::CAP_L0S_LSB +: 3] = l0s_exit;
		cap_word[pcie_link_regs_pkg::CAP_L1_LSB +: 3] = l1_exit;
		cap_word[pcie_link_regs_pkg::CAP_DLL_BIT] = !UPSTREAM && dl_active_rpt_capable;
		cap_word[pcie_link_regs_pkg::CAP_BWN_BIT] = !UPSTREAM;
		cap_word[pcie_link_regs_pkg::CAP_PORT_LSB +: 8] = port_num;
	end

	// control word: rcb and retrain read zero, upper half and reserved bits zero
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[pcie_link_regs_pkg::CTL_ASPM_LSB +: 2] = aspm_ctrl;
		ctrl_word[pcie_link_regs_pkg::CTL_RCB]      = 1'b0;
		ctrl_word[pcie_link_regs_pkg::CTL_LINK_DIS] = link_disable;
		ctrl_word[pcie_link_regs_pkg::CTL_RETRAIN]  = 1'b0;
		ctrl_word[pcie_link_regs_pkg::CTL_CCLK]     = common_clock;
		ctrl_word[pcie_link_regs_pkg::CTL_EXT_SYNC] = ext_synch;
		ctrl_word[pcie_link_regs_pkg::CTL_HAWD]     = hw_width_disable;
		ctrl_word[pcie_link_regs_pkg::CTL_LBMIE]    = bw_mgmt_int_en;
		ctrl_word[pcie_link_regs_pkg::CTL_LABIE]    = auto_bw_int_en;
	end

	always_comb begin
		unique case (rd_addr)
			pcie_link_regs_pkg::LINK_CAP_OFS:   rd_word = cap_word;
			pcie_link_regs_pkg::LINK_CTRL_OFS:  rd_word = ctrl_word;
			pcie_link_regs_pkg::INT_STATUS_OFS: rd_word = {30'h0, int_status};
			pcie_link_regs_pkg::INT_ENABLE_OFS: rd_word = {30'h0, int_enable};
			default:                            rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend) begin
			hrdata <= rd_word;
		end
	end

	// capability fields change only through the side load port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			max_speed    <= pcie_link_regs_pkg::MAX_SPEED_RST;
			aspm_support <= pcie_link_regs_pkg::ASPM_SUP_RST;
			l0s_exit     <= pcie_link_regs_pkg::L0S_EXIT_RST;
			l1_exit      <= pcie_link_regs_pkg::L1_EXIT_RST;
			port_num     <= PORT_RST;
		end else if (cap_load) begin
			max_speed    <= cap_load_data[pcie_link_regs_pkg::CAP_SPEED_LSB +: 4];
			aspm_support <= cap_load_data[pcie_link_regs_pkg::CAP_ASPM_LSB +: 2];
			l0s_exit     <= cap_load_data[pcie_link_regs_pkg::CAP_L0S_LSB +: 3];
			l1_exit      <= cap_load_data[pcie_link_regs_pkg::CAP_L1_LSB +: 3];
			port_num     <= cap_load_data[pcie_link_regs_pkg::CAP_PORT_LSB +: 8];
		end
	end

	// link control fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aspm_ctrl        <= 2'h0;
			link_disable     <= 1'b0;
			common_clock     <= 1'b0;
			ext_synch        <= 1'b0;
			hw_width_disable <= 1'b0;
			bw_mgmt_int_en   <= 1'b0;
			auto_bw_int_en   <= 1'b0;
		end else if (wr_ctrl) begin
			aspm_ctrl        <= hwdata[pcie_link_regs_pkg::CTL_ASPM_LSB +: 2];
			common_clock     <= hwdata[pcie_link_regs_pkg::CTL_CCLK];
			ext_synch        <= hwdata[pcie_link_regs_pkg::CTL_EXT_SYNC];
			hw_width_disable <= hwdata[pcie_link_regs_pkg::CTL_HAWD];
			if (!UPSTREAM) begin
				link_disable   <= hwdata[pcie_link_regs_pkg::CTL_LINK_DIS];
				bw_mgmt_int_en <= hwdata[pcie_link_regs_pkg::CTL_LBMIE];
				auto_bw_int_en <= hwdata[pcie_link_regs_pkg::CTL_LABIE];
			end
		end
	end

	// one-cycle retrain request on downstream ports
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retrain_start <= 1'b0;
		end else begin
			retrain_start <= wr_ctrl && !UPSTREAM && hwdata[pcie_link_regs_pkg::CTL_RETRAIN];
		end
	end

	// receiver L0s entry stays permitted independent of ASPM control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_l0s_allowed <= 1'b1;
		end else begin
			rx_l0s_allowed <= 1'b1;
		end
	end

	// ordered set counts for L0s and L1 exit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fts_count <= NORM_FTS;
			ts1_count <= NORM_TS1;
		end else begin
			fts_count <= ext_synch ? pcie_link_regs_pkg::EXT_FTS_COUNT : NORM_FTS;
			ts1_count <= ext_synch ? pcie_link_regs_pkg::EXT_TS1_COUNT : NORM_TS1;
		end
	end

	// sticky bandwidth event flags; a set in the clear cycle wins
	always_comb begin
		int_set = '0;
		int_set[pcie_link_regs_pkg::INT_BW_MGMT] = bw_mgmt_event;
		int_set[pcie_link_regs_pkg::INT_AUTO_BW] = auto_bw_event;
		int_clr = wr_clr ? hwdata[pcie_link_regs_pkg::INT_W-1:0] : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status <= '0;
			int_enable <= '0;
		end else begin
			int_status <= (int_status & ~int_clr) | int_set;
			if (wr_inten) begin
				int_enable <= hwdata[pcie_link_regs_pkg::INT_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_enable);
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic rd_cap;
	logic rd_ctrl;
	assign rd_cap  = rd_pend && (rd_addr == pcie_link_regs_pkg::LINK_CAP_OFS);
	assign rd_ctrl = rd_pend && (rd_addr == pcie_link_regs_pkg::LINK_CTRL_OFS);
	logic rd_stat;
	logic rd_other;
	assign rd_stat  = rd_pend && (rd_addr == pcie_link_regs_pkg::INT_STATUS_OFS);
	assign rd_other = rd_pend && (rd_addr != pcie_link_regs_pkg::LINK_CAP_OFS)
		&& (rd_addr != pcie_link_regs_pkg::LINK_CTRL_OFS)
		&& (rd_addr != pcie_link_regs_pkg::INT_STATUS_OFS)
		&& (rd_addr != pcie_link_regs_pkg::INT_ENABLE_OFS);

	AST_SPEED_ONLY_LOAD: assert property (!cap_load |=> $stable(max_speed))
		else $error("max speed changed without a load");
	AST_WIDTH_READ: assert property (rd_cap |=> hrdata[9:4] == 6'h01)
		else $error("max width read wrong");
	AST_ASPM_SUP_LOAD: assert property (cap_load |=> aspm_support == $past(cap_load_data[11:10]))
		else $error("aspm support not loaded");
	AST_L0S_LOAD: assert property (cap_load |=> l0s_exit == $past(cap_load_data[14:12]))
		else $error("l0s exit latency not loaded");
	AST_L1_ONLY_LOAD: assert property (!cap_load |=> $stable(l1_exit))
		else $error("l1 exit latency changed without a load");
	AST_DLL_BIT: assert property (rd_cap |=> hrdata[20] == (!UPSTREAM && $past(dl_active_rpt_capable)))
		else $error("dll active reporting bit wrong");
	AST_BWN_BIT: assert property (rd_cap |=> hrdata[21] == !UPSTREAM && hrdata[23:22] == 2'h0)
		else $error("bandwidth notification bit wrong");
	AST_PORT_LOAD: assert property (cap_load |=> port_num == $past(cap_load_data[31:24]))
		else $error("port number not loaded");
	AST_ASPM_WRITE: assert property (wr_ctrl |=> aspm_ctrl == $past(hwdata[1:0]))
		else $error("aspm control not written");
	AST_RX_L0S: assert property (rx_l0s_allowed)
		else $error("receiver L0s entry blocked");
	AST_CTRL_ZERO_BITS: assert property (rd_ctrl |=> hrdata[3] == 1'b0 && hrdata[5] == 1'b0 && hrdata[31:12] == 20'h0)
		else $error("control read shows a zero-only bit set");
	AST_UP_NO_DISABLE: assert property (!UPSTREAM || (!link_disable && !bw_mgmt_int_en))
		else $error("upstream port control bit set");
	AST_RETRAIN_PULSE: assert property (retrain_start |-> !UPSTREAM && $past(wr_ctrl && hwdata[5]) ##1 !retrain_start)
		else $error("retrain pulse wrong");
	AST_EXT_SYNCH: assert property (ext_synch [*2] |-> fts_count == 13'h1000 && ts1_count == 11'h400)
		else $error("extended synch counts wrong");
	AST_IRQ_LEVEL: assert property (irq == $past(|(int_status & int_enable)))
		else $error("interrupt level wrong");
	AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	// capability fields as read back and loaded
	AST_SPEED_READ: assert property (rd_cap |=> hrdata[3:0] == $past(max_speed))
		else $error("max speed read wrong");
	AST_SPEED_LOAD: assert property (cap_load |=> max_speed == $past(cap_load_data[3:0]))
		else $error("max speed not loaded");
	AST_ASPM_SUP_READ: assert property (rd_cap |=> hrdata[11:10] == $past(aspm_support))
		else $error("aspm support read wrong");
	AST_ASPM_SUP_ONLY_LOAD: assert property (!cap_load |=> $stable(aspm_support))
		else $error("aspm support changed without a load");
	AST_L0S_READ: assert property (rd_cap |=> hrdata[14:12] == $past(l0s_exit))
		else $error("l0s exit latency read wrong");
	AST_L0S_ONLY_LOAD: assert property (!cap_load |=> $stable(l0s_exit))
		else $error("l0s exit latency changed without a load");
	AST_L1_READ: assert property (rd_cap |=> hrdata[17:15] == $past(l1_exit))
		else $error("l1 exit latency read wrong");
	AST_L1_LOAD: assert property (cap_load |=> l1_exit == $past(cap_load_data[17:15]))
		else $error("l1 exit latency not loaded");
	AST_PORT_READ: assert property (rd_cap |=> hrdata[31:24] == $past(port_num))
		else $error("port number read wrong");
	AST_PORT_ONLY_LOAD: assert property (!cap_load |=> $stable(port_num))
		else $error("port number changed without a load");
	AST_CAP_RSVD: assert property (rd_cap |=> hrdata[19:18] == 2'h0)
		else $error("capability reserved bits set");

	// link control fields
	AST_CTRL_READBACK: assert property (rd_ctrl |=> hrdata[1:0] == $past(aspm_ctrl))
		else $error("aspm control read wrong");
	AST_CTRL_HOLD: assert property (!wr_ctrl |=> $stable(aspm_ctrl))
		else $error("aspm control changed without a write");
	AST_DIS_WRITE: assert property (wr_ctrl && !UPSTREAM |=>
		link_disable == $past(hwdata[4]))
		else $error("link disable not written");
	AST_UP_NO_RETRAIN: assert property (!UPSTREAM || !retrain_start)
		else $error("upstream port retrain requested");
	AST_RETRAIN_REQ: assert property (wr_ctrl && !UPSTREAM && hwdata[5] |=> retrain_start)
		else $error("retrain not requested");
	AST_CCLK_WRITE: assert property (wr_ctrl |=> common_clock == $past(hwdata[6]))
		else $error("common clock not written");
	AST_EXT_WRITE: assert property (wr_ctrl |=> ext_synch == $past(hwdata[7]))
		else $error("extended synch not written");
	AST_NORM_SYNCH: assert property ((!ext_synch) [*2] |->
		fts_count == NORM_FTS && ts1_count == NORM_TS1)
		else $error("normal ordered set counts wrong");
	AST_HAWD_WRITE: assert property (wr_ctrl |=> hw_width_disable == $past(hwdata[9]))
		else $error("width disable not written");
	AST_LBMIE_WRITE: assert property (wr_ctrl && !UPSTREAM |=>
		bw_mgmt_int_en == $past(hwdata[10]))
		else $error("bandwidth management enable not written");
	AST_LABIE_WRITE: assert property (wr_ctrl && !UPSTREAM |=>
		auto_bw_int_en == $past(hwdata[11]))
		else $error("autonomous bandwidth enable not written");
	AST_UP_LABIE_ZERO: assert property (!UPSTREAM || !auto_bw_int_en)
		else $error("upstream autonomous bandwidth enable set");
	AST_CTRL_RSVD: assert property (rd_ctrl |=> hrdata[2] == 1'b0 && hrdata[8] == 1'b0)
		else $error("control reserved bits set");

	// interrupt status, enable and bus answers
	AST_STATUS_SET: assert property ((|int_set) |=> &(int_status | ~$past(int_set)))
		else $error("status bit not set");
	AST_STATUS_CLR: assert property (wr_clr && !(|int_set) |=>
		!(|(int_status & $past(int_clr))))
		else $error("status bit not cleared");
	AST_STATUS_HOLD: assert property (!wr_clr |=> &(int_status | ~$past(int_status)))
		else $error("status bit lost without a clear");
	AST_STATUS_READ: assert property (rd_stat |=> hrdata == {30'h0, $past(int_status)})
		else $error("status read wrong");
	AST_ENABLE_WRITE: assert property (wr_inten |=> int_enable == $past(hwdata[1:0]))
		else $error("interrupt enable not written");
	AST_UNMAPPED_READ: assert property (rd_other |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_HRDATA_HOLD: assert property (!rd_pend |=> $stable(hrdata))
		else $error("read data changed without a read");
	AST_WRITE_NO_WAIT: assert property (take && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	AST_OKAY: assert property (!hresp)
		else $error("response not okay");

	COV_CAP_READ: cover property (rd_cap ##1 hreadyout);
	COV_RETRAIN: cover property (retrain_start);
	COV_IRQ: cover property (!irq ##1 irq);
	COV_SET_CLR: cover property (wr_clr && (bw_mgmt_event || auto_bw_event));
	COV_CAP_LOAD: cover property (cap_load ##1 !cap_load);
endmodule

// ===== verif/link_partner_model.sv
// link partner model: completes retraining and raises bandwidth events
// assumes the same hclk domain as the register block
`timescale 1ns/1ps
module link_partner_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       retrain_start,
	input  wire logic       link_disable,
	input  wire logic       auto_req,
	output logic            bw_mgmt_event,
	output logic            auto_bw_event,
	output logic [7:0]      retrain_cnt
);
	logic [2:0] wait_cnt;
	// a retrain settles after a few cycles, no bandwidth management event while the link is disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 3'h0;
			retrain_cnt <= 8'h00;
			bw_mgmt_event <= 1'b0;
			auto_bw_event <= 1'b0;
		end else begin
			if (retrain_start) begin
				wait_cnt <= 3'h5;
				retrain_cnt <= retrain_cnt + 8'h01;
			end else if (wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end
			bw_mgmt_event <= (wait_cnt == 3'h1) && !link_disable;
			auto_bw_event <= auto_req;
		end
	end
endmodule

// ===== verif/pcie_port_link_cap_ctrl_regs_test.sv
// testbench: three ports (0 upstream) on one AHB-Lite master, one partner each
// assumes the register block answers writes at once and reads after one wait
`timescale 1ns/1ps
module pcie_port_link_cap_ctrl_regs_test;
	logic        hclk = 0, hresetn = 0, hwrite = 0, dl = 0, aq = 0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 0, hwdata = 0, cld = 0, rd, wd, ce;
	int          sel = 0, seed = 44, error_cnt = 0, cmp_count = 0, cyc = 0, rx, k;
	logic [2:0]  hsel, cap_load = 3'h0;
	logic [31:0] hrd[3];
	logic        hro[3], irq[3], rxl[3], ld[3], rs[3], bwe[3], abe[3];
	logic        hrsp[3], ccl[3], esy[3], hwd[3], lbe[3], lae[3];
	logic [1:0]  asp[3];
	logic [12:0] fts[3];
	logic [10:0] ts1[3];
	logic [7:0]  rcnt[3];
	assign hsel = 3'h1 << sel;
	always #20 hclk = ~hclk;
	for (genvar g = 0; g < 3; g++) begin : port
		pcie_port_link_cap_ctrl_regs #(.PORT_INDEX(g)) dut (
			.hclk(hclk), .hresetn(hresetn), .hsel(hsel[g]), .haddr(haddr),
			.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
			.hready(hro[g]), .hreadyout(hro[g]), .hresp(hrsp[g]), .hrdata(hrd[g]),
			.cap_load(cap_load[g]), .cap_load_data(cld), .dl_active_rpt_capable(dl),
			.bw_mgmt_event(bwe[g]), .auto_bw_event(abe[g]), .aspm_ctrl(asp[g]),
			.rx_l0s_allowed(rxl[g]), .link_disable(ld[g]), .retrain_start(rs[g]),
			.common_clock(ccl[g]), .ext_synch(esy[g]), .hw_width_disable(hwd[g]),
			.bw_mgmt_int_en(lbe[g]), .auto_bw_int_en(lae[g]), .fts_count(fts[g]),
			.ts1_count(ts1[g]), .irq(irq[g]));
		link_partner_model partner (
			.hclk(hclk), .hresetn(hresetn), .retrain_start(rs[g]),
			.link_disable(ld[g]), .auto_req(aq), .bw_mgmt_event(bwe[g]),
			.auto_bw_event(abe[g]), .retrain_cnt(rcnt[g]));
	end
	function automatic logic [31:0] cap_rst(input int p, input logic d);
		return {p[7:0], 2'h0, p != 0, (p != 0) & d, 5'h00, 3'h3, 2'h0, 6'h01, 4'h2};
	endfunction
	function automatic logic [31:0] ctl_msk(input int p);
		return (p == 0) ? 32'h0000_02c3 : 32'h0000_0ed3;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hro[sel] !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hro[sel] !== 1'b1);
		rd = hrd[sel];
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report;
		end
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int p = 0; p < 3; p++) begin
			sel <= p;
			rx = 0;
			rw(0, 12'h0cc, 0);
			chk("cap reset", cap_rst(p, 0), rd);
			rw(0, 12'h0d0, 0);
			chk("ctl reset", 0, rd);
			chk("fts normal", 13'h0080, fts[p]);
			for (int i = 0; i < 8; i++) begin
				wd = $random(seed);
				wd[1:0] = i[1:0];
				rx += (p != 0) & wd[5];
				rw(1, 12'h0d0, wd);
				rw(0, 12'h0d0, 0);
				chk("ctl", wd & ctl_msk(p), rd);
				chk("aspm", i[1:0], asp[p]);
				chk("l0s allowed", 1, rxl[p]);
				chk("disable", (p != 0) & wd[4], ld[p]);
				chk("fts", wd[7] ? 4096 : 128, fts[p]);
				chk("ts1", wd[7] ? 1024 : 16, ts1[p]);
				chk("common clock", wd[6], ccl[p]);
				chk("ext synch", wd[7], esy[p]);
				chk("width disable", wd[9], hwd[p]);
				chk("bw mgmt ie", (p != 0) & wd[10], lbe[p]);
				chk("auto bw ie", (p != 0) & wd[11], lae[p]);
				chk("hresp", 0, hrsp[p]);
				chk("retrains", rx, rcnt[p]);
			end
			rw(1, 12'h0d0, 0);
			rw(1, 12'h0cc, $random(seed));
			rw(0, 12'h0cc, 0);
			chk("cap write", cap_rst(p, 0), rd);
			rw(1, 12'h100, 32'hffff_ffff);
			rw(0, 12'h100, 0);
			chk("unmapped", 0, rd);
			@(posedge hclk);
			cap_load <= 3'h1 << p;
			cld <= $random(seed);
			dl <= 1'b1;
			@(posedge hclk);
			cap_load <= 3'h0;
			ce = (cap_rst(p, 1) & 32'h0030_03f0) | (cld & 32'hff03_fc0f);
			rw(0, 12'h0cc, 0);
			chk("cap loaded", ce, rd);
			dl <= 1'b0;
			$display("test port %0d done", p);
		end
		sel <= 1;
		rw(1, 12'h0e8, 3);
		rw(1, 12'h0e4, 3);
		rw(1, 12'h0d0, 32'h20);
		for (k = 0; k < 30 && irq[1] !== 1'b1; k++) @(posedge hclk);
		chk("irq set", 1, irq[1]);
		@(posedge hclk);
		aq <= 1'b1;
		@(posedge hclk);
		aq <= 1'b0;
		rw(0, 12'h0e0, 0);
		chk("status", 3, rd);
		rw(1, 12'h0e4, 0);
		repeat (2) @(posedge hclk);
		chk("irq masked", 0, irq[1]);
		rw(1, 12'h0e4, 3);
		repeat (2) @(posedge hclk);
		chk("irq unmasked", 1, irq[1]);
		rw(1, 12'h0e8, 3);
		repeat (2) @(posedge hclk);
		chk("irq cleared", 0, irq[1]);
		rw(0, 12'h0e0, 0);
		chk("status cleared", 0, rd);
		$display("test interrupt done");
		final_report;
	end
endmodule
